// *** core/irq_ctrl.sv ***
// Interrupt controller for an 8-bit core: two control registers in RAM.
// Assumes the core drives the RAM strobes, the phase pulse and acknowledge.
//
// Overview of operation
// [R1] High register bit 1 enables the time base interrupt.
// [R2] High register bit 2 enables the real time clock interrupt.
// [R3] High register bits 0, 3, 4 and 7 read as zero.
// [R4] High register bit 5 is the time base pending flag.
// [R5] High register bit 6 is the clock tick pending flag.
// [R6] Acknowledges held until exit-reenable, or enables set, stack not full.
// [R7] Exit-reenable sets global enable; plain exit leaves it alone.
// [R8] Requests are taken at the next second phase pulse.
// [R9] Fixed priority ext0, ext1, counter, time base, clock tick.
// [R10] Global enable low blocks every source.
// [R11] Low register at 0BH holds three flags, three enables, global.
// [R12] High register at 1EH holds two flags and their enables.
// [R13] A disabled source is never serviced despite its flag.
// [R14] Pending flags stay set until serviced or cleared by software.
// [R15] Timing sources keep raising requests during halt.
// [R16] Low layout: enables in bits 0..3, flags in 4..6, test bit 7.
// [R17] Acknowledge clears the source flag and the global enable.
// [R18] No acknowledge while the return stack is full.
// [R19] External pins set flags on falling, rising or either edge.
// [R20] Request and vector go out; one-cycle acknowledge returns.
`timescale 1ns/10ps
`include "irq_ctrl_params.svh"

module irq_ctrl (
    // Clock and reset.
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // Data RAM access from the core.
    input  wire irq_ctrl_pkg::ram_req_t ram_req,
    output logic [7:0]                  ram_rdata,
    // Interrupt sources.
    input  wire logic                   ext_irq_pin_a,
    input  wire logic                   ext_irq_pin_b,
    input  wire irq_ctrl_pkg::edge_sel_t edge_sel_a,
    input  wire irq_ctrl_pkg::edge_sel_t edge_sel_b,
    input  wire irq_ctrl_pkg::src_events_t src_events,
    // Core sequencer.
    input  wire logic                   second_phase_pulse,
    input  wire irq_ctrl_pkg::core_ctl_t core_ctl,
    output logic                        irq_req,
    output logic [7:0]                  irq_vector
);
    import irq_ctrl_pkg::*;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;

    logic [4:0] pend;
    logic [4:0] en;
    logic [4:0] live;
    logic       edge_a;
    logic       edge_b;
    logic       wr_low;
    logic       wr_high;

    // Edge detection looks only at the agreeing second and third stages.
    function automatic logic edge_hit(input logic cur, input logic last,
                                      input edge_sel_t sel);
        case (sel)
            EDGE_FALL: edge_hit = last & ~cur;
            EDGE_RISE: edge_hit = ~last & cur;
            EDGE_BOTH: edge_hit = last ^ cur;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

    // Source vectors in priority order, bit 0 highest.
    assign pend = {st_reg.high[`HIGH_RTC_PEND], st_reg.high[`HIGH_TB_PEND],
                   st_reg.low[`LOW_CNT_PEND], st_reg.low[`LOW_EXT1_PEND],
                   st_reg.low[`LOW_EXT0_PEND]};
    assign en = {st_reg.high[`HIGH_RTC_EN], st_reg.high[`HIGH_TB_EN],
                 st_reg.low[`LOW_CNT_EN], st_reg.low[`LOW_EXT1_EN],
                 st_reg.low[`LOW_EXT0_EN]};
    assign live = pend & en & {5{st_reg.low[`LOW_GLOBAL_EN]}}; // [R10] [R13]

    // Qualified strobes and pin edges.
    always_comb begin
        wr_low  = ram_req.wr && ram_req.addr == `ADDR_IRQ_CONTROL_LOW; // [R11]
        wr_high = ram_req.wr &&
                  ram_req.addr == `ADDR_IRQ_CONTROL_HIGH; // [R12]
        edge_a  = (st_reg.pin_a_sync[2] == st_reg.pin_a_sync[1]) &&
                  edge_hit(st_reg.pin_a_sync[1], st_reg.pin_a_last,
                           edge_sel_a); // [R19]
        edge_b  = (st_reg.pin_b_sync[2] == st_reg.pin_b_sync[1]) &&
                  edge_hit(st_reg.pin_b_sync[1], st_reg.pin_b_last,
                           edge_sel_b); // [R19]
    end

    // Next-state logic for registers, synchronisers and the request.
    always_comb begin
        st_next = st_reg;
        st_next.pin_a_sync = {st_reg.pin_a_sync[1:0], ext_irq_pin_a};
        st_next.pin_b_sync = {st_reg.pin_b_sync[1:0], ext_irq_pin_b};
        if (st_reg.pin_a_sync[2] == st_reg.pin_a_sync[1]) begin
            st_next.pin_a_last = st_reg.pin_a_sync[1];
        end
        if (st_reg.pin_b_sync[2] == st_reg.pin_b_sync[1]) begin
            st_next.pin_b_last = st_reg.pin_b_sync[1];
        end
        // Software writes come first; hardware events then win over them.
        if (wr_low) begin
            st_next.low = ram_req.wdata; // [R16]
        end
        if (wr_high) begin
            st_next.high = ram_req.wdata & `HIGH_IMPL_MASK; // [R3] [R1] [R2]
        end
        // Acknowledge clears the winner's flag and the global enable.
        if (core_ctl.ack && st_reg.state == ST_REQ) begin
            st_next.low[`LOW_GLOBAL_EN] = 1'b0; // [R17]
            case (st_reg.win)
                3'h0:    st_next.low[`LOW_EXT0_PEND] = 1'b0;
                3'h1:    st_next.low[`LOW_EXT1_PEND] = 1'b0;
                3'h2:    st_next.low[`LOW_CNT_PEND]  = 1'b0;
                3'h3:    st_next.high[`HIGH_TB_PEND] = 1'b0;
                3'h4:    st_next.high[`HIGH_RTC_PEND] = 1'b0;
                default: st_next.low[`LOW_GLOBAL_EN] = 1'b0;
            endcase
        end
        if (core_ctl.exit_reenable) begin
            st_next.low[`LOW_GLOBAL_EN] = 1'b1; // [R7] [R6]
        end
        // Event sources set flags; the set wins any same-cycle clear.
        if (edge_a) st_next.low[`LOW_EXT0_PEND] = 1'b1; // [R14]
        if (edge_b) st_next.low[`LOW_EXT1_PEND] = 1'b1;
        if (src_events.counter_overflow) st_next.low[`LOW_CNT_PEND] = 1'b1;
        if (src_events.tick_base) begin
            st_next.high[`HIGH_TB_PEND] = 1'b1; // [R4] [R15]
        end
        if (src_events.clock_tick) st_next.high[`HIGH_RTC_PEND] = 1'b1; // [R5]
        // Read data, with unimplemented bits at zero.
        if (ram_req.rd && ram_req.addr == `ADDR_IRQ_CONTROL_LOW) begin
            st_next.rdata = st_reg.low;
        end else if (ram_req.rd &&
                     ram_req.addr == `ADDR_IRQ_CONTROL_HIGH) begin
            st_next.rdata = st_reg.high & `HIGH_IMPL_MASK; // [R3]
        end else begin
            st_next.rdata = 8'h00;
        end
        // Request sequencing toward the core.
        case (st_reg.state)
            ST_IDLE: begin
                // Sampled only at the phase pulse, never with a full stack.
                if (second_phase_pulse && !core_ctl.stack_full &&
                    live != 5'h00) begin // [R8] [R18] [R6]
                    st_next.state   = ST_REQ;
                    st_next.irq_req = 1'b1; // [R20]
                    if (live[0]) begin // [R9]
                        st_next.win = 3'h0;
                        st_next.vector = `VEC_EXT0;
                    end else if (live[1]) begin
                        st_next.win = 3'h1;
                        st_next.vector = `VEC_EXT1;
                    end else if (live[2]) begin
                        st_next.win = 3'h2;
                        st_next.vector = `VEC_CNT;
                    end else if (live[3]) begin
                        st_next.win = 3'h3;
                        st_next.vector = `VEC_TB;
                    end else begin
                        st_next.win = 3'h4;
                        st_next.vector = `VEC_RTC;
                    end
                end
            end
            ST_REQ: begin
                if (core_ctl.ack) begin // [R20]
                    st_next.state   = ST_IDLE;
                    st_next.irq_req = 1'b0;
                end else if (live[st_reg.win] == 1'b0) begin
                    // Request withdrawn when software masks or clears it.
                    st_next.state   = ST_IDLE;
                    st_next.irq_req = 1'b0; // [R10] [R13]
                end
            end
            default: begin
                st_next.state   = ST_IDLE;
                st_next.irq_req = 1'b0;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '{pin_a_sync: 3'h7, pin_b_sync: 3'h7,
                        pin_a_last: 1'b1, pin_b_last: 1'b1,
                        low: `LOW_RESET, high: `HIGH_RESET,
                        rdata: 8'h00, irq_req: 1'b0, vector: 8'h00,
                        win: 3'h0, state: ST_IDLE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign ram_rdata  = st_reg.rdata;
    assign irq_req    = st_reg.irq_req;
    assign irq_vector = st_reg.vector;

    // Checks of the documented behaviour.
    property p_ack_clears_global;
        @(posedge core_clk) disable iff (sys_rst)
        (core_ctl.ack && irq_req && !core_ctl.exit_reenable)
            |=> !st_reg.low[`LOW_GLOBAL_EN];
    endproperty
    a_ack_clears_global: assert property (p_ack_clears_global) // [R17]
        else $error("Acknowledge did not clear the global enable.");

    property p_exit_sets_global;
        @(posedge core_clk) disable iff (sys_rst)
        core_ctl.exit_reenable |=> st_reg.low[`LOW_GLOBAL_EN];
    endproperty
    a_exit_sets_global: assert property (p_exit_sets_global) // [R7]
        else $error("Exit-reenable did not set the global enable.");

    property p_full_stack_blocks;
        @(posedge core_clk) disable iff (sys_rst)
        (!irq_req && core_ctl.stack_full) |=> !irq_req;
    endproperty
    a_full_stack_blocks: assert property (p_full_stack_blocks) // [R18]
        else $error("Request raised with a full stack.");

    property p_phase_only;
        @(posedge core_clk) disable iff (sys_rst)
        (!irq_req && !second_phase_pulse) |=> !irq_req;
    endproperty
    a_phase_only: assert property (p_phase_only) // [R8]
        else $error("Request raised outside the phase pulse.");

    property p_global_blocks;
        @(posedge core_clk) disable iff (sys_rst)
        (!irq_req && !st_reg.low[`LOW_GLOBAL_EN]) |=> !irq_req;
    endproperty
    a_global_blocks: assert property (p_global_blocks) // [R10]
        else $error("Request raised with global enable clear.");

    property p_ext0_first;
        @(posedge core_clk) disable iff (sys_rst)
        (!irq_req && second_phase_pulse && !core_ctl.stack_full && live[0])
            |=> irq_req && irq_vector == `VEC_EXT0;
    endproperty
    a_ext0_first: assert property (p_ext0_first) // [R9]
        else $error("Highest priority source did not win.");

    property p_flag_sticky;
        @(posedge core_clk) disable iff (sys_rst)
        (st_reg.high[`HIGH_TB_PEND] && !wr_high && !core_ctl.ack)
            |=> st_reg.high[`HIGH_TB_PEND];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [R14]
        else $error("Pending flag dropped without service or write.");

    property p_high_unused_zero;
        @(posedge core_clk) disable iff (sys_rst)
        $past(ram_req.rd && ram_req.addr == `ADDR_IRQ_CONTROL_HIGH)
            |-> (ram_rdata & ~`HIGH_IMPL_MASK) == 8'h00;
    endproperty
    a_high_unused_zero: assert property (p_high_unused_zero) // [R3]
        else $error("Unimplemented high bits read nonzero.");

    c_request: cover property (@(posedge core_clk) irq_req ##1 core_ctl.ack);
    c_rtc_vec: cover property (@(posedge core_clk) irq_vector == `VEC_RTC);
    c_exit: cover property (@(posedge core_clk) core_ctl.exit_reenable);
endmodule

// *** core/irq_ctrl_params.svh ***
// Constants of the interrupt controller: addresses, bit positions, vectors.
// Assumes an 8-bit data RAM bus with the core's own read/write strobes.
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
`define ADDR_IRQ_CONTROL_LOW  8'h0B
`define ADDR_IRQ_CONTROL_HIGH 8'h1E
`define LOW_GLOBAL_EN   0
`define LOW_EXT0_EN     1
`define LOW_EXT1_EN     2
`define LOW_CNT_EN      3
`define LOW_EXT0_PEND   4
`define LOW_EXT1_PEND   5
`define LOW_CNT_PEND    6
`define LOW_TEST        7
`define HIGH_TB_EN      1
`define HIGH_RTC_EN     2
`define HIGH_TB_PEND    5
`define HIGH_RTC_PEND   6
`define HIGH_IMPL_MASK  8'h66
`define LOW_RESET       8'h00
`define HIGH_RESET      8'h00
`define VEC_EXT0        8'h04
`define VEC_EXT1        8'h08
`define VEC_CNT         8'h0C
`define VEC_TB          8'h14
`define VEC_RTC         8'h18
`endif

// *** core/irq_ctrl_pkg.sv ***
// Types shared by the interrupt controller and its users.
// Assumes irq_ctrl_params.svh is on the include path.
package irq_ctrl_pkg;
    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2
    } edge_sel_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ram_req_t;

    typedef struct packed {
        logic tick_base;
        logic clock_tick;
        logic counter_overflow;
    } src_events_t;

    typedef struct packed {
        logic       ack;
        logic       exit_reenable;
        logic       stack_full;
    } core_ctl_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_REQ  = 2'b10
    } state_t;

    typedef struct packed {
        logic [2:0] pin_a_sync;
        logic [2:0] pin_b_sync;
        logic       pin_a_last;
        logic       pin_b_last;
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] rdata;
        logic       irq_req;
        logic [7:0] vector;
        logic [2:0] win;
        state_t     state;
    } ctrl_state_t;
endpackage

// *** bench/core_seq_model.sv ***
// Behavioural model of the core sequencer facing the interrupt controller.
// Assumes one clock shared with the controller; drives on falling edges.
`timescale 1ns/10ps

module core_seq_model (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Request side.
    input  wire logic       irq_req,
    input  wire logic [3:0] ack_delay,
    // Sequencer outputs.
    output logic            second_phase_pulse,
    output logic            ack
);
    logic [1:0] phase_reg = 2'h0;
    logic [3:0] wait_reg  = 4'h0;
    logic       pulse_reg = 1'b0;
    logic       ack_reg   = 1'b0;

    // Both outputs come from one shared process; nothing pulses before reset.
    assign second_phase_pulse = pulse_reg;
    assign ack                = ack_reg;

    // Phase pulse every fourth cycle; ack is one cycle, after a delay.
    always @(negedge core_clk) begin
        phase_reg = sys_rst ? 2'h0 : phase_reg + 2'h1;
        pulse_reg = (phase_reg == 2'h3);
        if (sys_rst || ack_reg || !irq_req) begin
            ack_reg = 1'b0;
            wait_reg = 4'h0;
        end else if (wait_reg == ack_delay) begin
            ack_reg = 1'b1;
        end else begin
            wait_reg = wait_reg + 4'h1;
        end
    end
endmodule

// *** bench/irq_ctrl_tb_top.sv ***
// Self-checking bench of the interrupt controller with a sequencer model.
// Assumes irq_ctrl_params.svh on the include path and a 250 MHz clock.
`timescale 1ns/10ps
`include "irq_ctrl_params.svh"

module irq_ctrl_tb_top;
    import irq_ctrl_pkg::*;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    ram_req_t    ram_req = '0;
    logic        pin_a = 1'b1;
    logic        pin_b = 1'b1;
    edge_sel_t   sel_a = EDGE_FALL;
    edge_sel_t   sel_b = EDGE_RISE;
    src_events_t events = '0;
    logic        exit_re = 1'b0;
    logic        stk_full = 1'b0;
    logic [3:0]  ack_delay = 4'h0;
    logic [7:0]  ram_rdata;
    logic [7:0]  irq_vector;
    logic        pulse;
    logic        ack;
    logic        irq_req;
    core_ctl_t   ctl;
    int          bad_count = 0;
    int          total_checks = 0;

    // Clock and acknowledge bundle.
    always #2 core_clk = ~core_clk;
    assign ctl = '{ack: ack, exit_reenable: exit_re, stack_full: stk_full};

    irq_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .ram_req(ram_req),
        .ram_rdata(ram_rdata), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .edge_sel_a(sel_a), .edge_sel_b(sel_b), .src_events(events),
        .second_phase_pulse(pulse), .core_ctl(ctl), .irq_req(irq_req),
        .irq_vector(irq_vector));

    core_seq_model seq (.core_clk(core_clk), .sys_rst(sys_rst),
        .irq_req(irq_req), .ack_delay(ack_delay),
        .second_phase_pulse(pulse), .ack(ack));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        ram_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        ram_req = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        ram_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        ram_req = '0;
        chk(ram_rdata, e);
    endtask

    // Waits for a request, checks its vector, lets the model acknowledge.
    task automatic wait_req(input logic [7:0] v);
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h0, irq_req}, 8'h01);
        chk(irq_vector, v);
        repeat (int'(ack_delay) + 3) @(negedge core_clk);
        chk({7'h0, irq_req}, 8'h00);
    endtask

    task automatic no_req(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            seen = seen | (irq_req !== 1'b0);
        end
        chk({7'h0, seen}, 8'h00);
    endtask

    task automatic reenable;
        @(negedge core_clk);
        exit_re = 1'b1;
        @(negedge core_clk);
        exit_re = 1'b0;
    endtask

    task automatic settle;
        repeat (6) @(negedge core_clk);
    endtask

    task automatic t_regs;
        rd(`ADDR_IRQ_CONTROL_LOW, `LOW_RESET);
        rd(`ADDR_IRQ_CONTROL_HIGH, `HIGH_RESET);
        wr(`ADDR_IRQ_CONTROL_HIGH, 8'hFF);
        rd(`ADDR_IRQ_CONTROL_HIGH, 8'h66);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h0E);
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h0E);
        wr(8'h0C, 8'h5A);
        rd(8'h0C, 8'h00);
        wr(`ADDR_IRQ_CONTROL_HIGH, 8'h00);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        $display("registers test done");
    endtask

    task automatic t_priority;
        logic [7:0] vec [5];
        logic [7:0] lo;
        logic [7:0] hi;
        vec = '{`VEC_EXT0, `VEC_EXT1, `VEC_CNT, `VEC_TB, `VEC_RTC};
        lo = 8'h7F;
        hi = 8'h66;
        // The delay is set before each re-enable and is never zero, so a
        // request raised during the re-enable still stands when looked at.
        ack_delay = 4'h1;
        wr(`ADDR_IRQ_CONTROL_HIGH, hi);
        wr(`ADDR_IRQ_CONTROL_LOW, lo);
        for (int i = 0; i < 5; i++) begin
            wait_req(vec[i]);
            if (i < 3) lo[i + 4] = 1'b0;
            else hi[i + 2] = 1'b0;
            lo[0] = 1'b0;
            rd(`ADDR_IRQ_CONTROL_LOW, lo);
            rd(`ADDR_IRQ_CONTROL_HIGH, hi);
            no_req(12);
            ack_delay = 4'(i + 2);
            reenable();
            lo[0] = 1'b1;
            rd(`ADDR_IRQ_CONTROL_LOW, lo);
        end
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        wr(`ADDR_IRQ_CONTROL_HIGH, 8'h00);
        $display("priority test done");
    endtask

    task automatic t_masking;
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h1E);
        no_req(12);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h1D);
        no_req(12);
        stk_full = 1'b1;
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h13);
        no_req(12);
        stk_full = 1'b0;
        wait_req(`VEC_EXT0);
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h02);
        // A raised request drops when software clears the global enable
        // before the core acknowledges; the flag stays for later service.
        ack_delay = 4'hF;
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h13);
        repeat (5) @(negedge core_clk);
        chk({7'h0, irq_req}, 8'h01);
        chk(irq_vector, `VEC_EXT0);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h12);
        @(negedge core_clk);
        chk({7'h0, irq_req}, 8'h00);
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h12);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        $display("masking test done");
    endtask

    task automatic t_pins;
        pin_a = 1'b0;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h10);
        pin_a = 1'b1;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h10);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        pin_b = 1'b0;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        pin_b = 1'b1;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h20);
        sel_a = EDGE_BOTH;
        pin_a = 1'b0;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h30);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        pin_a = 1'b1;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h10);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        // The fourth select code takes no edge at all.
        sel_b = edge_sel_t'(2'h3);
        pin_b = 1'b0;
        settle();
        pin_b = 1'b1;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h00);
        $display("pins test done");
    endtask

    task automatic t_sources;
        events = 3'b001;
        @(negedge core_clk);
        events = 3'b100;
        @(negedge core_clk);
        events = 3'b010;
        @(negedge core_clk);
        events = 3'b000;
        settle();
        rd(`ADDR_IRQ_CONTROL_LOW, 8'h40);
        rd(`ADDR_IRQ_CONTROL_HIGH, 8'h60);
        wr(`ADDR_IRQ_CONTROL_HIGH, 8'h64);
        wr(`ADDR_IRQ_CONTROL_LOW, 8'h41);
        wait_req(`VEC_RTC);
        rd(`ADDR_IRQ_CONTROL_HIGH, 8'h24);
        reenable();
        wr(`ADDR_IRQ_CONTROL_HIGH, 8'h26);
        wait_req(`VEC_TB);
        rd(`ADDR_IRQ_CONTROL_HIGH, 8'h06);
        $display("sources test done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence: reset for three cycles, then each scenario in turn.
    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        t_regs();
        t_priority();
        t_masking();
        t_pins();
        t_sources();
        stop_test();
    end

    // Watchdog at 20000 cycles, well beyond the few hundred cycles the scenarios need.
    initial begin
        #(4 * 20000);
        bad_count++;
        stop_test();
    end
endmodule
